/* core/xtc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "xtc_defines.svh"

module xtc_regs
  import xtc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [23:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [23:0] reg_rdata_out,
  output logic             reg_rvalid_out,
  input  wire logic        frame_tick_in,
  input  wire logic [15:0] raw_i_in,
  input  wire logic [15:0] raw_q_in,
  input  wire logic [15:0] light_xt_prog_q_in,
  input  wire logic [15:0] inner_xt_prog_i_in,
  input  wire logic [15:0] inner_xt_prog_q_in,
  input  wire logic [3:0]  tcoef_ch1_hc_low_nibble_in,
  input  wire logic [3:0]  auto_scale_exp_in,
  output logic      [23:0] light_xt_i_out,
  output logic      [23:0] light_xt_q_out,
  output logic      [23:0] inner_xt_i_out,
  output logic      [23:0] inner_xt_q_out,
  output logic      [3:0]  digital_scale_exp_out,
  output logic      [15:0] inphase_readback_out,
  output logic      [15:0] quadrature_readback_out,
  output logic      [11:0] tcoef_ch1_low_current_out,
  output logic      [11:0] tcoef_ch0_high_current_out,
  output logic      [11:0] tcoef_ch1_high_current_out,
  output logic      [15:0] inphase_xt_ch0_low_current_out,
  output logic             light_xt_cal_start_out,
  output logic             inner_xt_cal_start_out
);
  import xtc_pkg::*;

  // ----------------------------------------
  // State and reset image
  // ----------------------------------------
  localparam xtc_top_state_t RST_STATE = '{
    tcoef_a:  `XTC_RST_TCOEF_A,
    ctrl:     `XTC_RST_CTRL,
    tcoef_hi: `XTC_RST_TCOEF_HI,
    default:  '0
  };

  xtc_top_state_t st;
  xtc_top_state_t st_next;

  // ----------------------------------------
  // Control field views
  // ----------------------------------------
  logic [3:0]  tau_exp;
  logic [2:0]  light_scl;
  logic [2:0]  inner_scl;
  logic        light_cal;
  logic        inner_cal;
  logic [2:0]  rsel;
  logic        light_prog;
  logic        light_filt;
  logic        inner_prog;
  logic        inner_filt;
  logic        auto_off;
  logic [2:0]  fixed_code;
  logic        any_cal;

  assign tau_exp    = st.ctrl[`XTC_TAU_HI:`XTC_TAU_LO];
  assign light_scl  = st.ctrl[`XTC_LSCL_HI:`XTC_LSCL_LO];
  assign inner_scl  = st.ctrl[`XTC_ISCL_HI:`XTC_ISCL_LO];
  assign light_cal  = st.ctrl[`XTC_LCAL_BIT];
  assign inner_cal  = st.ctrl[`XTC_ICAL_BIT];
  assign rsel       = st.ctrl[`XTC_RSEL_HI:`XTC_RSEL_LO];
  assign light_prog = st.ctrl[`XTC_LPROG_BIT];
  assign light_filt = st.ctrl[`XTC_LFILT_BIT];
  assign inner_prog = st.ctrl[`XTC_IPROG_BIT];
  assign inner_filt = st.ctrl[`XTC_IFILT_BIT];
  assign auto_off   = st.ctrl[`XTC_AOFF_BIT];
  assign fixed_code = st.ctrl[`XTC_FSC_HI:`XTC_FSC_LO];
  assign any_cal    = light_cal | inner_cal;

  // ----------------------------------------
  // Calibration starts and frame enables
  // ----------------------------------------
  logic light_start;
  logic inner_start;
  logic light_en;
  logic inner_en;

  assign light_start = light_cal & ~st.light_cal_d;
  assign inner_start = inner_cal & ~st.inner_cal_d;
  assign light_en    = light_cal & frame_tick_in;
  assign inner_en    = inner_cal & frame_tick_in;

  // ----------------------------------------
  // Crosstalk estimators
  // ----------------------------------------
  logic [15:0] light_est_i;
  logic [15:0] light_est_q;
  logic [15:0] inner_est_i;
  logic [15:0] inner_est_q;
  xtc_filter u_light_i (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .start_in      (light_start),
    .en_in         (light_en),
    .use_filter_in (light_filt),
    .tau_exp_in    (tau_exp),
    .sample_in     (raw_i_in),
    .est_out       (light_est_i)
  );
  xtc_filter u_light_q (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .start_in      (light_start),
    .en_in         (light_en),
    .use_filter_in (light_filt),
    .tau_exp_in    (tau_exp),
    .sample_in     (raw_q_in),
    .est_out       (light_est_q)
  );
  xtc_filter u_inner_i (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .start_in      (inner_start),
    .en_in         (inner_en),
    .use_filter_in (inner_filt),
    .tau_exp_in    (tau_exp),
    .sample_in     (raw_i_in),
    .est_out       (inner_est_i)
  );
  xtc_filter u_inner_q (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .start_in      (inner_start),
    .en_in         (inner_en),
    .use_filter_in (inner_filt),
    .tau_exp_in    (tau_exp),
    .sample_in     (raw_q_in),
    .est_out       (inner_est_q)
  );

  // ----------------------------------------
  // Programmed value scaling
  // ----------------------------------------
  logic [23:0] light_prog_i;
  logic [23:0] light_prog_q;
  logic [23:0] inner_prog_i;
  logic [23:0] inner_prog_q;
  xtc_scale u_scl_light_i (
    .value_in   (st.tcoef_hi[`XTC_XI0L_HI:`XTC_XI0L_LO]),
    .exp_in     (light_scl),
    .scaled_out (light_prog_i)
  );
  xtc_scale u_scl_light_q (
    .value_in   (light_xt_prog_q_in),
    .exp_in     (light_scl),
    .scaled_out (light_prog_q)
  );
  xtc_scale u_scl_inner_i (
    .value_in   (inner_xt_prog_i_in),
    .exp_in     (inner_scl),
    .scaled_out (inner_prog_i)
  );
  xtc_scale u_scl_inner_q (
    .value_in   (inner_xt_prog_q_in),
    .exp_in     (inner_scl),
    .scaled_out (inner_prog_q)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next             = st;
    st_next.rvalid      = 1'b0;
    st_next.light_cal_d = light_cal;
    st_next.inner_cal_d = inner_cal;
    st_next.tc1h_lo     = tcoef_ch1_hc_low_nibble_in;

    if (reg_wr_in) begin
      case (reg_addr_in)
        `XTC_OFS_TCOEF_A: st_next.tcoef_a = reg_wdata_in;
        `XTC_OFS_CTRL: begin
          st_next.ctrl = reg_wdata_in;
          st_next.ctrl[`XTC_RSVD_BIT] = 1'b0;
        end
        `XTC_OFS_TCOEF_HI: st_next.tcoef_hi = reg_wdata_in;
        default: st_next.tcoef_a = st.tcoef_a;
      endcase
    end

    if (reg_rd_in) begin
      st_next.rvalid = 1'b1;
      case (reg_addr_in)
        `XTC_OFS_TCOEF_A:  st_next.rdata = st.tcoef_a;
        `XTC_OFS_CTRL:     st_next.rdata = st.ctrl;
        `XTC_OFS_TCOEF_HI: st_next.rdata = st.tcoef_hi;
        default:           st_next.rdata = 24'h000000;
      endcase
    end

    if (frame_tick_in) begin
      st_next.frame_cnt = st.frame_cnt + 16'h0001;
      st_next.raw_i     = raw_i_in;
      st_next.raw_q     = raw_q_in;
    end

    if (light_prog) begin
      st_next.light_i = light_prog_i;
      st_next.light_q = light_prog_q;
    end else begin
      st_next.light_i = {{8{light_est_i[15]}}, light_est_i};
      st_next.light_q = {{8{light_est_q[15]}}, light_est_q};
    end

    if (inner_prog) begin
      st_next.inner_i = inner_prog_i;
      st_next.inner_q = inner_prog_q;
    end else begin
      st_next.inner_i = {{8{inner_est_i[15]}}, inner_est_i};
      st_next.inner_q = {{8{inner_est_q[15]}}, inner_est_q};
    end

    if (auto_off || any_cal) begin
      st_next.scale_exp = `XTC_SCALE_BIAS - {1'b0, fixed_code};
    end else begin
      st_next.scale_exp = auto_scale_exp_in;
    end

    case (rsel)
      XTC_RB_INNER: begin
        st_next.rb_i = inner_est_i;
        st_next.rb_q = inner_est_q;
      end
      XTC_RB_LIGHT: begin
        st_next.rb_i = light_est_i;
        st_next.rb_q = light_est_q;
      end
      XTC_RB_RAW: begin
        st_next.rb_i = st.raw_i;
        st_next.rb_q = st.raw_q;
      end
      XTC_RB_FRAMES: begin
        st_next.rb_i = st.frame_cnt;
        st_next.rb_q = 16'h0000;
      end
      default: begin
        st_next.rb_i = 16'h0000;
        st_next.rb_q = 16'h0000;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= RST_STATE;
    end else begin
      st <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_out                  = st.rdata;
  assign reg_rvalid_out                 = st.rvalid;
  assign light_xt_i_out                 = st.light_i;
  assign light_xt_q_out                 = st.light_q;
  assign inner_xt_i_out                 = st.inner_i;
  assign inner_xt_q_out                 = st.inner_q;
  assign digital_scale_exp_out          = st.scale_exp;
  assign inphase_readback_out           = st.rb_i;
  assign quadrature_readback_out        = st.rb_q;
  assign light_xt_cal_start_out         = light_cal;
  assign inner_xt_cal_start_out         = inner_cal;
  assign tcoef_ch1_low_current_out      = st.tcoef_a[`XTC_TC1L_HI:`XTC_TC1L_LO];
  assign tcoef_ch0_high_current_out     = st.tcoef_a[`XTC_TC0H_HI:`XTC_TC0H_LO];
  assign tcoef_ch1_high_current_out     = {st.tcoef_hi[`XTC_TC1H_HI:`XTC_TC1H_LO], st.tc1h_lo};
  assign inphase_xt_ch0_low_current_out = st.tcoef_hi[`XTC_XI0L_HI:`XTC_XI0L_LO];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_ctrl_write;
    reg_wr_in && reg_addr_in == `XTC_OFS_CTRL;
  endsequence
  a_tau_written: assert property (
    s_ctrl_write |=> tau_exp == $past(reg_wdata_in[`XTC_TAU_HI:`XTC_TAU_LO])
  ) else $error("filter exponent not taken from the write");
  a_rsvd_reads_zero: assert property (
    (reg_rd_in && reg_addr_in == `XTC_OFS_CTRL) |=> reg_rdata_out[`XTC_RSVD_BIT] == 1'b0
  ) else $error("reserved control bit read back as one");
  a_rb_frames: assert property (
    (rsel == XTC_RB_FRAMES) |=> inphase_readback_out == $past(st.frame_cnt)
  ) else $error("frame counter not shown on readback");
  a_light_prog: assert property (
    light_prog |=> light_xt_i_out == ({{8{$past(inphase_xt_ch0_low_current_out[15])}},
      $past(inphase_xt_ch0_low_current_out)} << $past(light_scl))
  ) else $error("illumination correction not the scaled programmed value");
  a_inner_calib: assert property (
    !inner_prog |=> inner_xt_i_out[15:0] == $past(inner_est_i)
  ) else $error("internal correction not the calibrated value");
  a_scale_forced: assert property (
    (auto_off || any_cal) |=> digital_scale_exp_out == 4'(4'h6 - $past(fixed_code))
  ) else $error("forced scale not applied");
  a_scale_auto: assert property (
    (!auto_off && !any_cal) |=> digital_scale_exp_out == $past(auto_scale_exp_in)
  ) else $error("auto scale not passed through");
  a_tcoef_write: assert property (
    (reg_wr_in && reg_addr_in == `XTC_OFS_TCOEF_A) |=>
      tcoef_ch1_low_current_out == $past(reg_wdata_in[23:12]) &&
      tcoef_ch0_high_current_out == $past(reg_wdata_in[11:0])
  ) else $error("coefficient fields not stored");
  a_frame_count: assert property (
    frame_tick_in |=> st.frame_cnt == 16'($past(st.frame_cnt) + 16'h0001)
  ) else $error("frame counter did not advance");

endmodule

`default_nettype wire

/* core/xtc_defines.svh */
`ifndef XTC_DEFINES_SVH
`define XTC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define XTC_OFS_TCOEF_A      8'h2D
`define XTC_OFS_CTRL         8'h2E
`define XTC_OFS_TCOEF_HI     8'h2F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define XTC_RST_TCOEF_A      24'h000000
`define XTC_RST_CTRL         24'h8001A0
`define XTC_RST_TCOEF_HI     24'h000000

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define XTC_TAU_HI           23
`define XTC_TAU_LO           20
`define XTC_LSCL_HI          19
`define XTC_LSCL_LO          17
`define XTC_ISCL_HI          16
`define XTC_ISCL_LO          14
`define XTC_RSVD_BIT         13
`define XTC_LCAL_BIT         12
`define XTC_RSEL_HI          11
`define XTC_RSEL_LO          9
`define XTC_LPROG_BIT        8
`define XTC_LFILT_BIT        7
`define XTC_IPROG_BIT        6
`define XTC_IFILT_BIT        5
`define XTC_ICAL_BIT         4
`define XTC_AOFF_BIT         3
`define XTC_FSC_HI           2
`define XTC_FSC_LO           0

// ----------------------------------------
// Coefficient register fields
// ----------------------------------------
`define XTC_TC1L_HI          23
`define XTC_TC1L_LO          12
`define XTC_TC0H_HI          11
`define XTC_TC0H_LO          0
`define XTC_TC1H_HI          23
`define XTC_TC1H_LO          16
`define XTC_XI0L_HI          15
`define XTC_XI0L_LO          0

// ----------------------------------------
// Scaling and filter constants
// ----------------------------------------
`define XTC_SCALE_BIAS       4'h6
`define XTC_FRAC_ZERO        16'h0000

`endif

/* core/xtc_pkg.sv */
package xtc_pkg;

  typedef enum logic [2:0] {
    XTC_RB_INNER  = 3'h0,
    XTC_RB_LIGHT  = 3'h1,
    XTC_RB_RAW    = 3'h2,
    XTC_RB_FRAMES = 3'h3
  } xtc_rb_sel_t;

  typedef struct packed {
    logic        primed;
    logic [31:0] acc;
  } xtc_filt_state_t;

  typedef struct packed {
    logic [23:0] tcoef_a;
    logic [23:0] ctrl;
    logic [23:0] tcoef_hi;
    logic [15:0] frame_cnt;
    logic [15:0] raw_i;
    logic [15:0] raw_q;
    logic [23:0] rdata;
    logic        rvalid;
    logic [23:0] light_i;
    logic [23:0] light_q;
    logic [23:0] inner_i;
    logic [23:0] inner_q;
    logic [3:0]  scale_exp;
    logic [15:0] rb_i;
    logic [15:0] rb_q;
    logic        light_cal_d;
    logic        inner_cal_d;
    logic [3:0]  tc1h_lo;
  } xtc_top_state_t;

endpackage

/* core/xtc_scale.sv */
`timescale 1ns/1ps
`default_nettype none

module xtc_scale
  import xtc_pkg::*;
(
  input  wire logic [15:0] value_in,
  input  wire logic [2:0]  exp_in,
  output logic      [23:0] scaled_out
);

  // ----------------------------------------
  // Power of two scaling, sign kept
  // ----------------------------------------
  logic signed [23:0] wide;

  always_comb begin
    wide       = $signed({{8{value_in[15]}}, value_in});
    scaled_out = 24'(wide <<< exp_in);
  end

endmodule

`default_nettype wire

/* core/xtc_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "xtc_defines.svh"

module xtc_filter
  import xtc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_in,
  input  wire logic        en_in,
  input  wire logic        use_filter_in,
  input  wire logic [3:0]  tau_exp_in,
  input  wire logic [15:0] sample_in,
  output logic      [15:0] est_out
);
  import xtc_pkg::*;

  xtc_filt_state_t    st;
  xtc_filt_state_t    st_next;
  logic signed [32:0] diff;
  logic signed [32:0] step;

  // ----------------------------------------
  // Frame rate estimator
  // ----------------------------------------
  always_comb begin
    st_next = st;
    diff    = $signed({sample_in[15], sample_in, `XTC_FRAC_ZERO}) - $signed({st.acc[31], st.acc});
    step    = diff >>> tau_exp_in;
    if (start_in) begin
      st_next.primed = 1'b0;
    end else if (en_in) begin
      if (!use_filter_in || !st.primed) begin
        st_next.acc = {sample_in, `XTC_FRAC_ZERO};
      end else begin
        st_next.acc = st.acc + step[31:0];
      end
      st_next.primed = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= st_next;
    end
  end

  assign est_out = st.acc[31:16];

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_restart;
    en_in && !start_in && !st.primed;
  endsequence

  a_direct_sample: assert property (
    (en_in && !start_in && !use_filter_in) |=> est_out == $past(sample_in)
  ) else $error("direct sampling did not load the sample");

  a_restart_load: assert property (
    s_restart |=> est_out == $past(sample_in)
  ) else $error("first frame after start did not load the sample");

  a_hold_estimate: assert property (
    (!en_in && !start_in) |=> $stable(est_out)
  ) else $error("estimate changed without an enabled frame");

endmodule

`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import xtc_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [23:0] wdata;
  logic        wr;
  logic        rd;
  logic [23:0] rdata;
  logic        rvalid;
  logic        tick;
  logic [15:0] raw_i;
  logic [15:0] raw_q;
  logic [15:0] pq_l;
  logic [15:0] pi_n;
  logic [15:0] pq_n;
  logic [3:0]  nib;
  logic [3:0]  ase;
  logic [23:0] li;
  logic [23:0] lq;
  logic [23:0] ni;
  logic [23:0] nq;
  logic [3:0]  dse;
  logic [15:0] rbi;
  logic [15:0] rbq;
  logic [11:0] tc1l;
  logic [11:0] tc0h;
  logic [11:0] tc1h;
  logic [15:0] xi0l;
  logic        lcs;
  logic        ics;
  logic [15:0] seed;
  logic [23:0] a;
  logic [23:0] b;
  logic [23:0] d;
  int          cyc;
  int          mismatches;
  int          n_tests;

  xtc_regs dut_u (
    .core_clk_in                    (clk),
    .rst_n_in                       (rst_n),
    .reg_addr_in                    (addr),
    .reg_wdata_in                   (wdata),
    .reg_wr_in                      (wr),
    .reg_rd_in                      (rd),
    .reg_rdata_out                  (rdata),
    .reg_rvalid_out                 (rvalid),
    .frame_tick_in                  (tick),
    .raw_i_in                       (raw_i),
    .raw_q_in                       (raw_q),
    .light_xt_prog_q_in             (pq_l),
    .inner_xt_prog_i_in             (pi_n),
    .inner_xt_prog_q_in             (pq_n),
    .tcoef_ch1_hc_low_nibble_in     (nib),
    .auto_scale_exp_in              (ase),
    .light_xt_i_out                 (li),
    .light_xt_q_out                 (lq),
    .inner_xt_i_out                 (ni),
    .inner_xt_q_out                 (nq),
    .digital_scale_exp_out          (dse),
    .inphase_readback_out           (rbi),
    .quadrature_readback_out        (rbq),
    .tcoef_ch1_low_current_out      (tc1l),
    .tcoef_ch0_high_current_out     (tc0h),
    .tcoef_ch1_high_current_out     (tc1h),
    .inphase_xt_ch0_low_current_out (xi0l),
    .light_xt_cal_start_out         (lcs),
    .inner_xt_cal_start_out         (ics)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  function automatic logic [23:0] sx(input logic [15:0] v);
    return {{8{v[15]}}, v};
  endfunction

  function automatic logic [23:0] scl(input logic [15:0] v, input logic [2:0] e);
    return sx(v) << e;
  endfunction

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] ad, input logic [23:0] dt);
    addr = ad;
    wdata = dt;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [23:0] exp);
    addr = ad;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({23'h0, rvalid}, 24'h000001);
    chk(rdata, exp);
    @(negedge clk);
  endtask

  task automatic frame(input logic [15:0] vi, input logic [15:0] vq);
    raw_i = vi;
    raw_q = vq;
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0; rst_n = 1'b0; addr = 8'h00; wdata = 24'h000000; wr = 1'b0; rd = 1'b0;
    tick = 1'b0; raw_i = 16'h0000; raw_q = 16'h0000; pq_l = 16'h0000; pi_n = 16'h0000;
    pq_n = 16'h0000; nib = 4'h0; ase = 4'h0; cyc = 0; mismatches = 0; n_tests = 0;
    seed = 16'h92DE;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rdchk(8'h2D, 24'h000000);
    rdchk(8'h2E, 24'h8001A0);
    rdchk(8'h2F, 24'h000000);
    rdchk(8'h40, 24'h000000);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 24'hFFFFFF : 24'({rnd(), rnd()});
      b = (i == 1) ? 24'hFFFFFF : 24'({rnd(), rnd()});
      nib = 4'(rnd());
      wreg(8'h2D, a);
      wreg(8'h2F, b);
      chk({12'h0, tc1l}, {12'h0, a[23:12]});
      chk({12'h0, tc0h}, {12'h0, a[11:0]});
      chk({12'h0, tc1h}, {12'h0, b[23:16], nib});
      chk({8'h0, xi0l}, {8'h0, b[15:0]});
      rdchk(8'h2D, a);
      rdchk(8'h2F, b);
      d = (24'({rnd(), rnd()}) | 24'h002000) & 24'hFFEFEF;
      wreg(8'h2E, d);
      rdchk(8'h2E, d & 24'hFFDFFF);
    end
    for (int e = 0; e < 8; e++) begin
      b = {8'h00, rnd()};
      pq_l = rnd(); pi_n = rnd(); pq_n = rnd();
      wreg(8'h2F, b);
      wreg(8'h2E, 24'h8001E0 | (24'(e) << 17) | (24'(7 - e) << 14));
      chk(li, scl(b[15:0], 3'(e)));
      chk(lq, scl(pq_l, 3'(e)));
      chk(ni, scl(pi_n, 3'(7 - e)));
      chk(nq, scl(pq_n, 3'(7 - e)));
    end
    for (int c = 0; c < 8; c++) begin
      ase = 4'(rnd());
      wreg(8'h2E, 24'h8001A0 | 24'(c));
      chk({20'h0, dse}, {20'h0, ase});
      wreg(8'h2E, 24'h8001A8 | 24'(c));
      chk({20'h0, dse}, {20'h0, 4'(6 - c)});
      wreg(8'h2E, 24'h0001B0 | 24'(c));
      chk({20'h0, dse}, {20'h0, 4'(6 - c)});
      repeat (5) frame(16'h0000, 16'h0000);
      wreg(8'h2E, 24'h8001A0);
    end
    wreg(8'h2E, 24'h000190);
    chk({23'h0, ics}, 24'h000001);
    for (int k = 0; k < 5; k++) begin
      a = 24'({rnd(), rnd()});
      frame(a[15:0], a[23:8]);
      chk(ni, sx(a[15:0]));
      chk(nq, sx(a[23:8]));
      chk({8'h0, rbi}, {8'h0, a[15:0]});
    end
    wreg(8'h2E, 24'h800180);
    frame(rnd(), rnd());
    chk(ni, sx(a[15:0]));
    chk(nq, sx(a[23:8]));
    wreg(8'h2E, 24'h1001B0);
    frame(16'h0000, 16'h0000);
    frame(16'h0100, 16'hFF00);
    chk(ni, 24'h000080);
    chk(nq, 24'hFFFF80);
    repeat (8) frame(16'h0100, 16'hFF00);
    wreg(8'h2E, 24'h001200);
    chk({23'h0, lcs}, 24'h000001);
    repeat (4) frame(rnd(), rnd());
    a = 24'({rnd(), rnd()});
    frame(a[15:0], a[23:8]);
    chk(li, sx(a[15:0]));
    chk(lq, sx(a[23:8]));
    chk({8'h0, rbi}, {8'h0, a[15:0]});
    wreg(8'h2E, 24'h001400);
    chk({8'h0, rbi}, {8'h0, a[15:0]});
    chk({8'h0, rbq}, {8'h0, a[23:8]});
    wreg(8'h2E, 24'h800600);
    b = {8'h00, rbi};
    frame(rnd(), rnd());
    chk({8'h0, rbi}, b + 24'h000001);
    chk({8'h0, rbq}, 24'h000000);
    for (int s = 4; s < 8; s++) begin
      wreg(8'h2E, 24'h800000 | (24'(s) << 9));
      chk({rbi, 8'h00}, 24'h000000);
      chk({8'h0, rbq}, 24'h000000);
    end
    print_verdict();
  end

endmodule

`default_nettype wire
